/* pkg/power_seq_pkg.sv */
/*
  constants for the module power state sequencer: debounce and
  sequencing times, reset stretch and warning lead counts.
  assumes a 50 MHz always-on reference clock.
*/
package power_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 20;
  // debounce settle time for push-buttons and switches
  localparam int unsigned DEBOUNCE_US     = 10;
  localparam int unsigned DEBOUNCE_CYC    =
    (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
  // system reset stretch after power good or reset press
  localparam int unsigned RESET_HOLD_US   = 20;
  localparam int unsigned RESET_HOLD_CYC  =
    (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // suspend warning lead before entering a sleep state
  localparam int unsigned WARN_LEAD_US    = 2;
  localparam int unsigned WARN_LEAD_CYC   =
    (WARN_LEAD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 16;

  // input indices of the debounced group
  localparam int unsigned IDX_POWER_BUTTON_N      = 0;
  localparam int unsigned IDX_RSTBTN      = 1;
  localparam int unsigned IDX_PCIE_WAKE   = 2;
  localparam int unsigned IDX_GEN_WAKE    = 3;
  localparam int unsigned IDX_LID         = 4;
  localparam int unsigned IDX_SLEEP       = 5;
  localparam int unsigned N_IN            = 6;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_PG,
    ST_RESET,
    ST_WORK,
    ST_WARN_S3,
    ST_SLEEP,
    ST_WARN_S5
  } pstate_t;

endpackage : power_seq_pkg

/* verilog/input_debouncer.sv */
/*
  one input: two-flop synchroniser, then a counter that accepts a new
  level only after it has been stable for the settle count.
  assumes the input is an idle-high active-low pin (pull-up).
*/
`timescale 1ns/10ps
module input_debouncer
  import power_seq_pkg::*;
#(
  parameter int unsigned SETTLE = DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  // raw pin and cleaned level
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             level;
    logic [CNT_W-1:0] cnt;
  } deb_t;

  deb_t cur;
  deb_t next_cur;

  //--------------------------------------------------------------------
  // synchronise and filter
  //--------------------------------------------------------------------
  always_comb begin
    next_cur    = cur;
    next_cur.s1 = i_pin;
    next_cur.s2 = cur.s1;
    if (cur.s2 == cur.level) begin
      next_cur.cnt = '0;
    end else if (cur.cnt >= CNT_W'(SETTLE - 1)) begin
      next_cur.level = cur.s2;
      next_cur.cnt   = '0;
    end else begin
      next_cur.cnt = cur.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign o_level = cur.level;

  settle_time_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_nrst)
    $changed(cur.level) |->
      $past(cur.s2) == cur.level && $past(cur.cnt) >= CNT_W'(SETTLE - 1))
    else $error("debounced level changed without a stable input");

endmodule : input_debouncer

/* verilog/module_power_state_sequencer.sv */
/*
  power state and reset sequencer of a compact computer module.
  assumes all carrier-side pins are idle-high active-low pulled-up
  inputs except power good, and a free-running always-on clock.
*/
`timescale 1ns/10ps
module module_power_state_sequencer
  import power_seq_pkg::*;
#(
  parameter int unsigned SETTLE     = DEBOUNCE_CYC,
  parameter int unsigned RESET_HOLD = RESET_HOLD_CYC,
  parameter int unsigned WARN_LEAD  = WARN_LEAD_CYC
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  // carrier buttons and switches
  input  wire logic i_power_button_n,
  input  wire logic i_reset_button_n,
  input  wire logic i_lid_switch_n,
  input  wire logic i_sleep_button_n,
  // wake sources and supply status
  input  wire logic i_pcie_wake_n,
  input  wire logic i_general_wake_n,
  input  wire logic i_power_good_in,
  // status and reset outputs
  output logic      o_carrier_reset_out_n,
  output logic      o_suspend_warning_n,
  output logic      o_suspend_ram_state_n,
  output logic      o_hibernate_state_n,
  output logic      o_soft_off_state_n
);

  // all checks below run on the one always-on clock
  default clocking chk_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  //--------------------------------------------------------------------
  // input conditioning
  //--------------------------------------------------------------------
  logic [N_IN-1:0] raw_n;
  logic [N_IN-1:0] clean_n;

  assign raw_n[IDX_POWER_BUTTON_N]    = i_power_button_n;
  assign raw_n[IDX_RSTBTN]    = i_reset_button_n;
  assign raw_n[IDX_PCIE_WAKE] = i_pcie_wake_n;
  assign raw_n[IDX_GEN_WAKE]  = i_general_wake_n;
  assign raw_n[IDX_LID]       = i_lid_switch_n;
  assign raw_n[IDX_SLEEP]     = i_sleep_button_n;

  // floating pins read high and so never leave the idle level
  for (genvar g = 0; g < N_IN; g++) begin : g_deb
    input_debouncer #(
      .SETTLE (SETTLE)
    ) u_deb (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_pin     (raw_n[g]),
      .o_level   (clean_n[g])
    );
  end

  typedef struct packed {
    logic             pg_s1;
    logic             pg_s2;
    logic [N_IN-1:0]  prev_n;
    pstate_t          st;
    logic [CNT_W-1:0] cnt;
    logic             rst_n;
    logic             warn_n;
    logic             s3_n;
    logic             s5_n;
  } seq_t;

  seq_t cur;
  seq_t next_cur;

  logic [N_IN-1:0] press;
  logic            pg;
  logic            wake;
  logic            toggle_sleep;

  // one event per falling edge of a debounced level
  assign press        = cur.prev_n & ~clean_n;
  assign pg           = cur.pg_s2;
  assign wake         = press[IDX_PCIE_WAKE] | press[IDX_GEN_WAKE];
  assign toggle_sleep = press[IDX_LID] | press[IDX_SLEEP];

  //--------------------------------------------------------------------
  // sequencer
  //--------------------------------------------------------------------
  always_comb begin
    next_cur        = cur;
    next_cur.pg_s1  = i_power_good_in;
    next_cur.pg_s2  = cur.pg_s1;
    next_cur.prev_n = clean_n;
    next_cur.cnt    = cur.cnt + CNT_W'(1);
    case (cur.st)
      ST_OFF: begin
        next_cur.cnt = '0;
        if (press[IDX_POWER_BUTTON_N] || wake) begin
          next_cur.st = ST_WAIT_PG;
        end
      end
      ST_WAIT_PG: begin
        next_cur.cnt = '0;
        if (press[IDX_POWER_BUTTON_N]) begin
          next_cur.st = ST_OFF;
        end else if (pg) begin
          next_cur.st = ST_RESET;
        end
      end
      ST_RESET: begin
        if (!pg) begin
          next_cur.st  = ST_WAIT_PG;
          next_cur.cnt = '0;
        end else if (press[IDX_POWER_BUTTON_N]) begin
          next_cur.st  = ST_WARN_S5;
          next_cur.cnt = '0;
        end else if (cur.cnt >= CNT_W'(RESET_HOLD - 1)) begin
          next_cur.st  = ST_WORK;
          next_cur.cnt = '0;
        end
      end
      ST_WORK: begin
        next_cur.cnt = '0;
        if (!pg) begin
          next_cur.st = ST_WAIT_PG;
        end else if (press[IDX_POWER_BUTTON_N]) begin
          next_cur.st = ST_WARN_S5;
        end else if (press[IDX_RSTBTN]) begin
          next_cur.st = ST_RESET;
        end else if (toggle_sleep) begin
          next_cur.st = ST_WARN_S3;
        end
      end
      ST_WARN_S3: begin
        if (cur.cnt >= CNT_W'(WARN_LEAD - 1)) begin
          next_cur.st  = ST_SLEEP;
          next_cur.cnt = '0;
        end
      end
      ST_SLEEP: begin
        next_cur.cnt = '0;
        if (press[IDX_POWER_BUTTON_N] || toggle_sleep || wake) begin
          next_cur.st = ST_WAIT_PG;
        end
      end
      ST_WARN_S5: begin
        if (cur.cnt >= CNT_W'(WARN_LEAD - 1)) begin
          next_cur.st  = ST_OFF;
          next_cur.cnt = '0;
        end
      end
      default: begin
        next_cur.st  = ST_OFF;
        next_cur.cnt = '0;
      end
    endcase
    // outputs registered from the next state
    next_cur.rst_n  = (next_cur.st == ST_WORK) ||
                      (next_cur.st == ST_WARN_S3) ||
                      (next_cur.st == ST_WARN_S5);
    next_cur.warn_n = !((next_cur.st == ST_WARN_S3) ||
                        (next_cur.st == ST_WARN_S5) ||
                        (next_cur.st == ST_SLEEP) ||
                        (next_cur.st == ST_OFF));
    next_cur.s3_n   = !((next_cur.st == ST_SLEEP) ||
                        (next_cur.st == ST_OFF));
    next_cur.s5_n   = (next_cur.st != ST_OFF);
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur <= '{pg_s1: 1'b0, pg_s2: 1'b0, prev_n: '1, st: ST_OFF,
               cnt: '0, rst_n: 1'b0, warn_n: 1'b0, s3_n: 1'b0,
               s5_n: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign o_carrier_reset_out_n = cur.rst_n;
  assign o_suspend_warning_n   = cur.warn_n;
  assign o_suspend_ram_state_n = cur.s3_n;
  assign o_soft_off_state_n    = cur.s5_n;
  assign o_hibernate_state_n   = cur.s5_n;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  sequence warn_phase_s;
    cur.st == ST_WARN_S3 && $past(cur.st) == ST_WORK;
  endsequence

  sequence sleep_entry_s;
    ##[1:1000] cur.st == ST_SLEEP;
  endsequence

  boot_needs_pg_a: assert property (
    cur.st == ST_WAIT_PG && !pg |=> cur.st != ST_RESET)
    else $error("reset phase entered without power good");
  power_button_n_on_a: assert property (
    cur.st == ST_OFF && press[IDX_POWER_BUTTON_N] |=> cur.st == ST_WAIT_PG)
    else $error("power button did not start power up");
  power_button_n_off_a: assert property (
    cur.st == ST_WORK && pg && press[IDX_POWER_BUTTON_N] |=> cur.st == ST_WARN_S5)
    else $error("power button did not start power down");
  rstbtn_reset_a: assert property (
    cur.st == ST_WORK && pg && !press[IDX_POWER_BUTTON_N] && press[IDX_RSTBTN]
    |=> !o_carrier_reset_out_n)
    else $error("reset button did not assert system reset");
  reset_out_a: assert property (
    cur.st == ST_RESET |-> !o_carrier_reset_out_n)
    else $error("system reset not asserted during reset phase");
  warn_before_s3_a: assert property (
    warn_phase_s |-> !o_suspend_warning_n && o_suspend_ram_state_n)
    else $error("suspend warning missing ahead of sleep");
  sleep_reach_a: assert property (
    warn_phase_s |-> sleep_entry_s)
    else $error("sleep not reached after warning");
  s3_state_a: assert property (
    cur.st == ST_SLEEP |-> !o_suspend_ram_state_n && o_soft_off_state_n)
    else $error("S3 output wrong in suspend to RAM");
  s5_state_a: assert property (
    cur.st == ST_OFF |-> !o_soft_off_state_n)
    else $error("S5 output not asserted in soft off");
  s4_s5_tie_a: assert property (
    o_hibernate_state_n == o_soft_off_state_n)
    else $error("S4 and S5 outputs differ");
  wake_on_a: assert property (
    cur.st == ST_OFF && wake |=> cur.st == ST_WAIT_PG)
    else $error("wake input did not power on");
  lid_sleep_a: assert property (
    cur.st == ST_SLEEP && toggle_sleep |=> cur.st == ST_WAIT_PG)
    else $error("lid or sleep button did not resume");
  // an event needs its pin low at the synchroniser three edges earlier
  idle_quiet_a: assert property (
    press != '0 |-> ($past(raw_n, 3) & press) == '0)
    else $error("event seen on idle inputs");

endmodule : module_power_state_sequencer

/* dv/carrier_model.sv */
/*
  carrier board model: push-buttons, switches, wake sources, supply.
  assumes the bench calls its tasks; pins change at falling edges.
*/
`timescale 1ns/10ps
module carrier_model (
  // clock
  input  wire logic i_ref_clk,
  // pins toward the module, indexed as the package inputs
  output logic [5:0] o_pins_n,
  output logic       o_power_good
);
  // pull-ups hold every idle or unconnected pin high
  initial o_pins_n = 6'h3f;
  initial o_power_good = 1'b0;

  task automatic press(input int idx, input int len);
    @(negedge i_ref_clk);
    o_pins_n[idx] = 1'b0;
    repeat (len) @(negedge i_ref_clk);
    o_pins_n[idx] = 1'b1;
  endtask : press

  // supply good is raised once rails are up and can be dropped again while running
  task automatic set_good(input logic v);
    @(negedge i_ref_clk);
    o_power_good = v;
  endtask : set_good
endmodule : carrier_model

/* dv/tb_top.sv */
/*
  self-checking bench of the power state sequencer.
  assumes carrier_model drives all carrier pins; short counts used.
*/
`timescale 1ns/10ps
module tb_top;
  import power_seq_pkg::*;
  localparam int ST = 4, RH = 8, WL = 4, PL = 7;
  localparam int RST = 4, WRN = 3, S3 = 2, HIB = 1, S5 = 0;
  logic       i_ref_clk;
  logic       i_nrst;
  logic [5:0] pin_n;
  logic       pg;
  wire  [4:0] o;
  int         n_mismatch = 0;
  int         n_tests = 0;
  int         c;
  string      onm [5] = '{"soft off", "hibernate", "s3", "warning",
                          "reset"};

  carrier_model cm_u (.i_ref_clk(i_ref_clk), .o_pins_n(pin_n),
    .o_power_good(pg));
  module_power_state_sequencer #(.SETTLE(ST), .RESET_HOLD(RH),
    .WARN_LEAD(WL)) dut_u (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_power_button_n(pin_n[IDX_POWER_BUTTON_N]),
    .i_reset_button_n(pin_n[IDX_RSTBTN]),
    .i_lid_switch_n(pin_n[IDX_LID]),
    .i_sleep_button_n(pin_n[IDX_SLEEP]),
    .i_pcie_wake_n(pin_n[IDX_PCIE_WAKE]),
    .i_general_wake_n(pin_n[IDX_GEN_WAKE]),
    .i_power_good_in(pg),
    .o_carrier_reset_out_n(o[RST]), .o_suspend_warning_n(o[WRN]),
    .o_suspend_ram_state_n(o[S3]), .o_hibernate_state_n(o[HIB]),
    .o_soft_off_state_n(o[S5]));

  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk

  task automatic chk_cyc(input string nm, input int lo, input int hi,
                         input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_cyc

  // bounded wait for an output level, cycles taken in cyc
  task automatic wait_out(input int b, input logic v, input int lim,
                          output int cyc);
    cyc = 0;
    while (o[b] !== v) begin
      if (cyc == lim) begin
        n_mismatch++;
        $display("unexpected %s: expected %b seen %b", onm[b], v, o[b]);
        summarize();
      end
      @(negedge i_ref_clk);
      cyc++;
    end
  endtask : wait_out

  task automatic t_idle();
    repeat (40) @(negedge i_ref_clk);
    for (int b = 0; b < 5; b++) chk("off output", 1'b0, o[b]);
  endtask : t_idle

  task automatic t_boot();
    cm_u.press(IDX_POWER_BUTTON_N, PL);
    wait_out(S5, 1'b1, 40, c);
    repeat (40) @(negedge i_ref_clk);
    chk("reset without good", 1'b0, o[RST]);
    cm_u.set_good(1'b1);
    wait_out(RST, 1'b1, 60, c);
    chk_cyc("boot reset length", RH, RH + 6, c);
    chk("warning in work", 1'b1, o[WRN]);
    chk("s3 in work", 1'b1, o[S3]);
    chk("hibernate in work", 1'b1, o[HIB]);
  endtask : t_boot

  task automatic t_glitch();
    cm_u.press(IDX_POWER_BUTTON_N, 2);
    cm_u.press(IDX_LID, 2);
    cm_u.press(IDX_RSTBTN, 2);
    repeat (30) @(negedge i_ref_clk);
    chk("reset after glitch", 1'b1, o[RST]);
    chk("warning after glitch", 1'b1, o[WRN]);
  endtask : t_glitch

  task automatic t_rstbtn();
    cm_u.press(IDX_RSTBTN, PL);
    wait_out(RST, 1'b0, 40, c);
    chk("s5 in reset", 1'b1, o[S5]);
    wait_out(RST, 1'b1, 60, c);
    chk_cyc("button reset length", RH - 1, RH + 2, c);
  endtask : t_rstbtn

  task automatic t_sleep(input int idx);
    cm_u.press(idx, PL);
    wait_out(WRN, 1'b0, 40, c);
    chk("reset during warning", 1'b1, o[RST]);
    wait_out(S3, 1'b0, 40, c);
    chk_cyc("sleep warning lead", WL - 1, WL + 2, c);
    chk("s5 in sleep", 1'b1, o[S5]);
    chk("reset in sleep", 1'b0, o[RST]);
    cm_u.press(idx, PL);
    wait_out(RST, 1'b1, 80, c);
    chk("s3 after wake", 1'b1, o[S3]);
  endtask : t_sleep

  task automatic t_off_wake(input int idx);
    cm_u.press(IDX_POWER_BUTTON_N, PL);
    wait_out(WRN, 1'b0, 40, c);
    wait_out(S5, 1'b0, 40, c);
    chk_cyc("off warning lead", WL - 1, WL + 2, c);
    chk("hibernate in off", 1'b0, o[HIB]);
    chk("reset in off", 1'b0, o[RST]);
    cm_u.press(idx, PL);
    wait_out(RST, 1'b1, 80, c);
    chk("s5 after wake", 1'b1, o[S5]);
  endtask : t_off_wake

  task automatic t_pg_loss();
    cm_u.set_good(1'b0);
    wait_out(RST, 1'b0, 20, c);
    chk("s5 without good", 1'b1, o[S5]);
    cm_u.set_good(1'b1);
    wait_out(RST, 1'b1, 60, c);
  endtask : t_pg_loss

  // reset in mid-run: outputs drop at once, no false event after release
  task automatic t_mid_reset();
    @(negedge i_ref_clk);
    i_nrst = 1'b0;
    #1;
    for (int b = 0; b < 5; b++) chk("output in reset", 1'b0, o[b]);
    repeat (3) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    repeat (30) @(negedge i_ref_clk);
    for (int b = 0; b < 5; b++) chk("off after reset", 1'b0, o[b]);
  endtask : t_mid_reset

  initial begin
    i_nrst = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    t_idle();
    t_boot();
    t_glitch();
    t_rstbtn();
    t_sleep(IDX_LID);
    t_sleep(IDX_SLEEP);
    t_off_wake(IDX_PCIE_WAKE);
    t_off_wake(IDX_GEN_WAKE);
    t_pg_loss();
    t_mid_reset();
    summarize();
  end
endmodule : tb_top
